// ==== pkg/smbus_host_regs.vh ====
`ifndef SMBUS_HOST_REGS_VH
`define SMBUS_HOST_REGS_VH

// System clock rate in kHz (100 MHz)
`define CLK_KHZ 100000
// Default bus clock rate in kHz; legal range is 10 to 400
`define SCL_KHZ_DEF 100
// Quiet time after power-up before the target answers, in ms
`define PWRUP_MS 15

// Kind of byte being moved on the bus
`define BT_ADDR 2'h0
`define BT_REG 2'h1
`define BT_WDAT 2'h2
`define BT_RDAT 2'h3

// Bit positions inside one nine-clock byte slot
`define BIT_LAST_DATA 4'h7
`define BIT_ACK 4'h8

// Quarter-period phase numbers
`define Q_RELEASE 2'h0
`define Q_SAMPLE 2'h1
`define Q_LOWER 2'h2
`define Q_NEXT 2'h3

`endif

// ==== hw/smbus_host.v ====
`include "smbus_host_regs.vh"

// Behaviour
// - Target select pin held at ground
// - Wait 15 ms after power-up first
// - Start: data falls while clock high
// - Address byte: 7-bit address plus direction
// - Bytes are eight bits, MSB first
// - Host acks read bytes except the last
// - Bus clock between 10 and 400 kHz
// - Block transfers carry no byte count
// - Single write: address, register, data, stop
// - Single read: register, repeated start, read
module smbus_host #(
  parameter [31:0] SCL_KHZ = `SCL_KHZ_DEF,
  parameter [31:0] PWRUP_CYCLES = `PWRUP_MS * `CLK_KHZ,
  parameter DW = 8
) (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_cmd_valid,
  output wire o_cmd_ready,
  input wire i_cmd_read,
  input wire i_cmd_use_reg,
  input wire [6:0] i_cmd_addr,
  input wire [7:0] i_cmd_reg,
  input wire [7:0] i_cmd_len,
  input wire i_tx_valid,
  output wire o_tx_ready,
  input wire [7:0] i_tx_data,
  output wire o_rx_valid,
  input wire i_rx_ready,
  output wire [DW-1:0] o_rx_data,
  output wire o_done,
  output wire o_nack,
  input wire i_host_bus_clock_line,
  output wire o_host_bus_clock_line_oe_n,
  input wire i_host_bus_data_line,
  output wire o_host_bus_data_line_oe_n,
  output wire o_target_select_low
);

  ////////////////////////////////////////////////////////////////////////////
  // Constants and states

  // Quarter of a bus clock period, rounded up so the rate never exceeds SCL_KHZ
  localparam [31:0] QTR_CYCLES = (`CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);

  localparam [5:0] S_PWRUP = 6'h01;
  localparam [5:0] S_IDLE = 6'h02;
  localparam [5:0] S_START = 6'h04;
  localparam [5:0] S_BIT = 6'h08;
  localparam [5:0] S_HOLD = 6'h10;
  localparam [5:0] S_STOP = 6'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg [5:0] state_r; // One-hot sequencer state
  reg [1:0] q_r; // Quarter within the current bit
  reg [31:0] cnt_r; // Quarter timer, also the power-up timer
  reg [3:0] bit_r; // Bit within the byte slot, 8 is the ack
  reg [7:0] shift_r; // Outgoing bits leave at the top, incoming enter at the bottom
  reg [1:0] bt_r; // Kind of the current byte
  reg rw_r; // Direction bit carried by the current address byte
  reg rd_op_r; // Command is a read
  reg [6:0] addr_r; // Target address of the command
  reg [7:0] reg_r; // Register pointer to send
  reg [7:0] len_r; // Data bytes still to move
  reg ack_r; // Acknowledge level sampled in the ninth clock
  reg scl_oe_n_r; // Clock line enable, low pulls the line low
  reg sda_oe_n_r; // Data line enable, low pulls the line low
  reg cmd_ready_r;
  reg tx_ready_r;
  reg done_r;
  reg nack_r;
  reg sel_low_r;
  reg scl_m_r; // Synchroniser first stages, read only by the second
  reg sda_m_r;
  reg scl_s_r; // Synchronised line levels
  reg sda_s_r;
  reg v0_r; // Receive buffer: entry 0 faces the consumer
  reg v1_r;
  reg [DW-1:0] d0_r;
  reg [DW-1:0] d1_r;

  ////////////////////////////////////////////////////////////////////////////
  // Derived strobes

  // The timer runs while the clock is driven low or a released clock really reads high, so a
  // stretched clock lengthens the high phase instead of cutting it short
  wire gate = scl_s_r | ~scl_oe_n_r;
  wire tick = gate & (cnt_r == QTR_CYCLES - 32'h1);
  wire end_byte = (state_r == S_BIT) & tick & (q_r == `Q_NEXT) & (bit_r == `BIT_ACK);
  wire push = end_byte & (bt_r == `BT_RDAT);
  wire pop = v0_r & i_rx_ready;
  wire buf_full = v0_r & v1_r;

  ////////////////////////////////////////////////////////////////////////////
  // Line synchronisers: two flops before any logic looks at the pins

  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      scl_m_r <= 1'b1;
      sda_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      scl_m_r <= i_host_bus_clock_line;
      sda_m_r <= i_host_bus_data_line;
      scl_s_r <= scl_m_r;
      sda_s_r <= sda_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry receive buffer; a full buffer parks the bus with the clock low

  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      v0_r <= 1'b0;
      v1_r <= 1'b0;
      d0_r <= {DW{1'b0}};
      d1_r <= {DW{1'b0}};
    end else if (pop) begin
      // Consumer takes entry 0; entry 1 moves up behind it
      if (v1_r) begin
        d0_r <= d1_r;
        v1_r <= push;
        if (push) begin
          d1_r <= shift_r[DW-1:0];
        end
      end else begin
        v0_r <= push;
        if (push) begin
          d0_r <= shift_r[DW-1:0];
        end
      end
    end else if (push) begin
      if (!v0_r) begin
        v0_r <= 1'b1;
        d0_r <= shift_r[DW-1:0];
      end else begin
        v1_r <= 1'b1;
        d1_r <= shift_r[DW-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus sequencer

  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state_r <= S_PWRUP;
      q_r <= `Q_RELEASE;
      cnt_r <= 32'h0;
      bit_r <= 4'h0;
      shift_r <= 8'hFF;
      bt_r <= `BT_ADDR;
      rw_r <= 1'b0;
      rd_op_r <= 1'b0;
      addr_r <= 7'h00;
      reg_r <= 8'h00;
      len_r <= 8'h00;
      ack_r <= 1'b1;
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
      cmd_ready_r <= 1'b0;
      tx_ready_r <= 1'b0;
      done_r <= 1'b0;
      nack_r <= 1'b0;
      sel_low_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      nack_r <= 1'b0;
      sel_low_r <= 1'b0;
      // Quarter timer, held while a stretched clock is still low
      if (state_r != S_PWRUP && state_r != S_IDLE && state_r != S_HOLD) begin
        if (tick) begin
          cnt_r <= 32'h0;
          q_r <= q_r + 2'h1;
        end else if (gate) begin
          cnt_r <= cnt_r + 32'h1;
        end
      end
      case (state_r)
        S_PWRUP: begin
          // Target ignores the bus for a while after power-up
          if (cnt_r == PWRUP_CYCLES - 32'h1) begin
            cnt_r <= 32'h0;
            cmd_ready_r <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            cnt_r <= cnt_r + 32'h1;
          end
        end
        S_IDLE: begin
          if (i_cmd_valid && cmd_ready_r) begin
            cmd_ready_r <= 1'b0;
            rd_op_r <= i_cmd_read;
            addr_r <= i_cmd_addr;
            reg_r <= i_cmd_reg;
            // A read always moves at least one byte
            len_r <= (i_cmd_read && i_cmd_len == 8'h00) ? 8'h01 : i_cmd_len;
            // Receive Byte skips the pointer and reads at once
            rw_r <= i_cmd_read & ~i_cmd_use_reg;
            shift_r <= {i_cmd_addr, i_cmd_read & ~i_cmd_use_reg};
            bt_r <= `BT_ADDR;
            sda_oe_n_r <= 1'b1;
            q_r <= `Q_RELEASE;
            cnt_r <= 32'h0;
            state_r <= S_START;
          end
        end
        S_START: begin
          // Also serves as repeated start: data released first, then clock
          if (tick) begin
            case (q_r)
              `Q_RELEASE: scl_oe_n_r <= 1'b1;
              `Q_SAMPLE: sda_oe_n_r <= 1'b0;
              `Q_LOWER: scl_oe_n_r <= 1'b0;
              default: begin
                bit_r <= 4'h0;
                sda_oe_n_r <= shift_r[7];
                state_r <= S_BIT;
              end
            endcase
          end
        end
        S_BIT: begin
          if (tick) begin
            case (q_r)
              `Q_RELEASE: scl_oe_n_r <= 1'b1;
              `Q_SAMPLE: begin
                if (bit_r == `BIT_ACK) begin
                  ack_r <= sda_s_r;
                end else begin
                  shift_r <= {shift_r[6:0], sda_s_r};
                end
              end
              `Q_LOWER: scl_oe_n_r <= 1'b0;
              default: begin
                if (bit_r == `BIT_LAST_DATA) begin
                  bit_r <= `BIT_ACK;
                  // Host acks every read byte but the last one
                  if (bt_r == `BT_RDAT) begin
                    sda_oe_n_r <= (len_r == 8'h01);
                  end else begin
                    sda_oe_n_r <= 1'b1;
                  end
                end else if (bit_r != `BIT_ACK) begin
                  bit_r <= bit_r + 4'h1;
                  sda_oe_n_r <= shift_r[7];
                end else if (bt_r != `BT_RDAT && ack_r) begin
                  // No acknowledge: wrong address or refused byte, give up
                  nack_r <= 1'b1;
                  sda_oe_n_r <= 1'b0;
                  state_r <= S_STOP;
                end else begin
                  case (bt_r)
                    `BT_ADDR: begin
                      if (rw_r) begin
                        bt_r <= `BT_RDAT;
                        state_r <= S_HOLD;
                      end else begin
                        bt_r <= `BT_REG;
                        bit_r <= 4'h0;
                        shift_r <= reg_r;
                        sda_oe_n_r <= reg_r[7];
                      end
                    end
                    `BT_REG: begin
                      if (rd_op_r) begin
                        // Repeated start, then the address with the read bit
                        bt_r <= `BT_ADDR;
                        rw_r <= 1'b1;
                        shift_r <= {addr_r, 1'b1};
                        sda_oe_n_r <= 1'b1;
                        state_r <= S_START;
                      end else if (len_r == 8'h00) begin
                        sda_oe_n_r <= 1'b0;
                        state_r <= S_STOP;
                      end else begin
                        bt_r <= `BT_WDAT;
                        tx_ready_r <= 1'b1;
                        state_r <= S_HOLD;
                      end
                    end
                    default: begin
                      // Data byte done; no count byte is ever sent
                      len_r <= len_r - 8'h01;
                      if (len_r == 8'h01) begin
                        sda_oe_n_r <= 1'b0;
                        state_r <= S_STOP;
                      end else begin
                        tx_ready_r <= (bt_r == `BT_WDAT);
                        state_r <= S_HOLD;
                      end
                    end
                  endcase
                end
              end
            endcase
          end
        end
        S_HOLD: begin
          // Clock parked low until data to send or room to receive
          if (bt_r == `BT_WDAT) begin
            if (i_tx_valid && tx_ready_r) begin
              tx_ready_r <= 1'b0;
              shift_r <= i_tx_data;
              sda_oe_n_r <= i_tx_data[7];
              bit_r <= 4'h0;
              q_r <= `Q_RELEASE;
              cnt_r <= 32'h0;
              state_r <= S_BIT;
            end
          end else if (!buf_full) begin
            shift_r <= 8'hFF;
            sda_oe_n_r <= 1'b1;
            bit_r <= 4'h0;
            q_r <= `Q_RELEASE;
            cnt_r <= 32'h0;
            state_r <= S_BIT;
          end
        end
        S_STOP: begin
          // Data low, clock up, then data up, then two quarters of bus free time
          if (tick) begin
            case (q_r)
              `Q_RELEASE: scl_oe_n_r <= 1'b1;
              `Q_SAMPLE: sda_oe_n_r <= 1'b1;
              `Q_LOWER: sda_oe_n_r <= 1'b1;
              default: begin
                done_r <= 1'b1;
                cmd_ready_r <= 1'b1;
                state_r <= S_IDLE;
              end
            endcase
          end
        end
        default: begin
          scl_oe_n_r <= 1'b1;
          sda_oe_n_r <= 1'b1;
          state_r <= S_IDLE;
          cmd_ready_r <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops

  assign o_cmd_ready = cmd_ready_r;
  assign o_tx_ready = tx_ready_r;
  assign o_rx_valid = v0_r;
  assign o_rx_data = d0_r;
  assign o_done = done_r;
  assign o_nack = nack_r;
  assign o_host_bus_clock_line_oe_n = scl_oe_n_r;
  assign o_host_bus_data_line_oe_n = sda_oe_n_r;
  assign o_target_select_low = sel_low_r;

endmodule

// ==== sim/smbus_host_properties.sv ====
module smbus_host_properties #(
  parameter [31:0] PWRUP_CYCLES = 32'h14,
  parameter DW = 8
) (
  input logic i_sys_clk,
  input logic i_resetn,
  input logic i_cmd_valid,
  input logic o_cmd_ready,
  input logic i_tx_valid,
  input logic o_tx_ready,
  input logic o_rx_valid,
  input logic i_rx_ready,
  input logic [DW-1:0] o_rx_data,
  input logic o_done,
  input logic o_nack,
  input logic o_host_bus_clock_line_oe_n,
  input logic o_host_bus_data_line_oe_n,
  input logic o_target_select_low
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles since reset release; saturates so it never wraps in long runs
  logic [31:0] pw_cnt_r;
  logic [31:0] pw_cnt_nxt;
  assign pw_cnt_nxt = (pw_cnt_r == PWRUP_CYCLES) ? pw_cnt_r : pw_cnt_r + 32'h1;
  always @(posedge i_sys_clk) begin
    if (!i_resetn) pw_cnt_r <= 32'h0;
    else pw_cnt_r <= pw_cnt_nxt;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Start: data pulled low while the clock is released
  sequence s_start;
    o_host_bus_clock_line_oe_n && $fell(o_host_bus_data_line_oe_n);
  endsequence
  // Stop: data released while the clock stays released
  sequence s_stop;
    o_host_bus_clock_line_oe_n && $past(o_host_bus_clock_line_oe_n) &&
      $rose(o_host_bus_data_line_oe_n);
  endsequence
  property p_quiet;
    (pw_cnt_r < PWRUP_CYCLES) |-> !o_cmd_ready;
  endproperty
  a_quiet: assert property (p_quiet) else $error("command taken too early");
  property p_take_start;
    i_cmd_valid && o_cmd_ready |=> !o_cmd_ready ##[0:400] s_start;
  endproperty
  a_take_start: assert property (p_take_start) else $error("no start");
  property p_stop_done;
    s_stop |-> ##[1:300] o_done;
  endproperty
  a_stop_done: assert property (p_stop_done) else $error("stop without done");
  property p_done_pulse;
    o_done |-> o_cmd_ready ##1 !o_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
  property p_nack_stop;
    o_nack |-> ##[1:1000] o_done;
  endproperty
  a_nack_stop: assert property (p_nack_stop) else $error("nack not closed");
  property p_idle;
    o_cmd_ready |-> o_host_bus_clock_line_oe_n && o_host_bus_data_line_oe_n;
  endproperty
  a_idle: assert property (p_idle) else $error("bus held while idle");
  property p_tx_take;
    i_tx_valid && o_tx_ready |=> !o_tx_ready;
  endproperty
  a_tx_take: assert property (p_tx_take) else $error("tx ready stuck");
  property p_rx_hold;
    o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx word lost");
  property p_sel;
    !o_target_select_low;
  endproperty
  a_sel: assert property (p_sel) else $error("select not grounded");
endmodule
bind smbus_host smbus_host_properties #(.PWRUP_CYCLES(PWRUP_CYCLES), .DW(DW)) i_props (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid),
  .o_cmd_ready(o_cmd_ready), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
  .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready), .o_rx_data(o_rx_data),
  .o_done(o_done), .o_nack(o_nack),
  .o_host_bus_clock_line_oe_n(o_host_bus_clock_line_oe_n),
  .o_host_bus_data_line_oe_n(o_host_bus_data_line_oe_n),
  .o_target_select_low(o_target_select_low));

// ==== sim/smbus_target_model.sv ====
module smbus_target_model #(
  parameter [6:0] OWN_ADDR = 7'h2C // Bus mode strap, first address
) (
  input wire i_scl, // Clock is only watched, never stretched
  input wire i_sda,
  output logic o_sda_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:255]; // Register file
  logic [7:0] sh; // Byte shifter
  logic [7:0] ptr; // Register pointer
  logic [1:0] mode; // 0 address, 1 pointer, 2 write data, 3 read data
  logic active;
  logic got;
  logic hack;
  int cnt;
  // Timeouts stay disabled, as after reset
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    o_sda_oe_n = 1'b1;
    active = 1'b0;
    ptr = 8'h00;
  end
  // Start or repeated start
  always @(negedge i_sda) if (i_scl) begin
    active = 1'b1;
    mode = 2'h0;
    cnt = 0;
    got = 1'b0;
  end
  // Stop returns to idle
  always @(posedge i_sda) if (i_scl) begin
    active = 1'b0;
    o_sda_oe_n = 1'b1;
  end
  // Sample on the high phase, MSB first
  always @(posedge i_scl) if (active) begin
    if (cnt < 8 && mode != 2'h3) sh = {sh[6:0], i_sda};
    if (cnt == 8 && mode == 2'h3) hack = !i_sda;
    cnt = (cnt == 8) ? 0 : cnt + 1;
  end
  // Drive only while the clock is low
  always @(negedge i_scl) if (active) begin
    if (cnt == 8 && mode != 2'h3) begin
      got = 1'b1;
      if (mode == 2'h0 && sh[7:1] != OWN_ADDR) active = 1'b0;
      else begin
        o_sda_oe_n = 1'b0;
        if (mode == 2'h0) mode = sh[0] ? 2'h3 : 2'h1;
        else if (mode == 2'h1) begin
          ptr = sh;
          mode = 2'h2;
        end else begin
          mem[ptr] = sh;
          ptr = ptr + 8'h01;
        end
      end
    end else if (cnt == 8) o_sda_oe_n = 1'b1;
    else if (cnt == 0 && got) begin
      o_sda_oe_n = 1'b1;
      if (mode == 2'h3 && hack) begin
        sh = mem[ptr];
        ptr = ptr + 8'h01;
        o_sda_oe_n = sh[7];
      end else if (mode == 2'h3) active = 1'b0;
    end else if (mode == 2'h3 && cnt > 0) o_sda_oe_n = sh[7 - cnt];
  end
endmodule

// ==== sim/smbus_host_tb_top.sv ====
module smbus_host_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [6:0] TGT = 7'h2C;
  localparam [31:0] PW = 32'h14;
  logic sys_clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0;
  logic use_reg = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [7:0] cmd_reg = 8'h00, cmd_len = 8'h00, tx_data = 8'h00, rx_data, r, d0, d1;
  logic cmd_ready, tx_ready, rx_valid, done, nack, scl_oe_n, sda_oe_n, tgt_oe_n, sel, nk;
  logic [7:0] ref_mem [0:255];
  logic [7:0] wq [$];
  logic [7:0] got [$];
  int err_total = 0, checks_done = 0, taken;
  wire scl = scl_oe_n; // Pull-up: only the host drives the clock
  wire sda = sda_oe_n & tgt_oe_n;
  always #5 sys_clk = ~sys_clk;
  smbus_host #(.SCL_KHZ(32'd400), .PWRUP_CYCLES(PW), .DW(8)) i_dut (
    .i_sys_clk(sys_clk), .i_resetn(resetn), .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready),
    .i_cmd_read(cmd_read), .i_cmd_use_reg(use_reg), .i_cmd_addr(cmd_addr),
    .i_cmd_reg(cmd_reg), .i_cmd_len(cmd_len), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .i_tx_data(tx_data), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready), .o_rx_data(rx_data),
    .o_done(done), .o_nack(nack), .i_host_bus_clock_line(scl),
    .o_host_bus_clock_line_oe_n(scl_oe_n), .i_host_bus_data_line(sda),
    .o_host_bus_data_line_oe_n(sda_oe_n), .o_target_select_low(sel));
  smbus_target_model #(.OWN_ADDR(TGT)) i_tgt (.i_scl(scl), .i_sda(sda), .o_sda_oe_n(tgt_oe_n));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] init_val(input int i);
    return 8'(i) ^ 8'h5A;
  endfunction
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] act);
    checks_done++;
    if (act !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, act);
    end
  endtask
  task automatic chk_flag(input string what, input logic exp, input logic act);
    chk_byte(what, {7'h00, exp}, {7'h00, act});
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One whole bus transaction; all inputs move on the falling edge
  task automatic xfer(input logic rd, ur, input logic [6:0] a, input logic [7:0] rg, n,
                      input int stall);
    int t;
    logic pc, pt;
    t = 0;
    taken = 0;
    nk = 1'b0;
    got.delete();
    @(negedge sys_clk);
    {cmd_valid, cmd_read, use_reg, cmd_addr, cmd_reg, cmd_len} = {1'b1, rd, ur, a, rg, n};
    tx_valid = !rd && wq.size() > 0;
    if (tx_valid) tx_data = wq[0];
    pc = cmd_ready;
    pt = tx_valid && tx_ready;
    while (t < 40000) begin
      @(negedge sys_clk);
      t++;
      if (pc) cmd_valid = 1'b0;
      pc = cmd_valid && cmd_ready;
      if (pt) begin
        void'(wq.pop_front());
        taken++;
        tx_valid = wq.size() > 0;
        tx_data = tx_valid ? wq[0] : ~tx_data;
      end
      pt = tx_valid && tx_ready;
      rx_ready = (t > stall) && ($urandom % 3 != 0);
      if (rx_ready && rx_valid) got.push_back(rx_data);
      if (nack) nk = 1'b1;
      if (done) break;
    end
    wq.delete();
    tx_valid = 1'b0;
    if (t >= 40000) chk_flag("done", 1'b1, 1'b0);
  endtask
  task automatic chk_rx(input logic [7:0] base, input int n);
    for (int k = 0; k < n; k++) chk_byte("rx_data", ref_mem[8'(base + k)], got[k]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #950000;
    chk_flag("watchdog", 1'b1, 1'b0);
    close_out();
  end
  initial begin
    for (int i = 0; i < 256; i++) ref_mem[i] = init_val(i);
    void'($urandom(46));
    repeat (20) @(negedge sys_clk);
    resetn = 1'b1;
    // Ready rises at the PW-th edge after release, so look one edge before it
    repeat (PW - 32'h1) @(negedge sys_clk);
    chk_flag("quiet_ready", 1'b0, cmd_ready);
    @(negedge sys_clk);
    chk_flag("ready_up", 1'b1, cmd_ready);
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    wq = '{d0, d1};
    xfer(1'b0, 1'b1, TGT, 8'hFF, 8'h02, 0);
    ref_mem[8'hFF] = d0;
    ref_mem[8'h00] = d1;
    chk_flag("w_nack", 1'b0, nk);
    chk_byte("w_taken", 8'h02, 8'(taken));
    xfer(1'b1, 1'b1, TGT, 8'hFF, 8'h02, 0);
    chk_rx(8'hFF, 2);
    r = 8'($urandom);
    xfer(1'b0, 1'b1, TGT, r, 8'h00, 0);
    xfer(1'b1, 1'b0, TGT, 8'h00, 8'h01, 0);
    chk_rx(r, 1);
    r = 8'($urandom);
    d0 = 8'($urandom);
    wq = '{d0};
    xfer(1'b0, 1'b1, TGT, r, 8'h01, 0);
    ref_mem[r] = d0;
    xfer(1'b1, 1'b1, TGT, r, 8'h01, 0);
    chk_rx(r, 1);
    wq = '{~d0};
    xfer(1'b0, 1'b1, TGT ^ 7'h01, r, 8'h01, 0);
    chk_flag("addr_nack", 1'b1, nk);
    chk_byte("nack_taken", 8'h00, 8'(taken));
    xfer(1'b1, 1'b1, TGT, r, 8'h01, 0);
    chk_rx(r, 1);
    r = 8'($urandom);
    xfer(1'b1, 1'b1, TGT, r, 8'h03, 16000);
    chk_rx(r, 3);
    close_out();
  end
endmodule
